//--- common/wol_defs.svh
`ifndef WOL_DEFS_SVH
`define WOL_DEFS_SVH

// Register map
`define WOL_WAKE_CONTROL_STATUS_OFF 8'h40
`define WOL_WAKE_CONTROL_STATUS_RST 32'h0000_0000
`define WOL_CTRL_RST 11'h000

// Control field positions inside the enable bits
`define WOL_BIT_PHY_EN 0
`define WOL_BIT_PAT0_EN 5
`define WOL_BIT_MAGIC_EN 9
`define WOL_BIT_PWPROT_EN 10

// Status field positions in the register word
`define WOL_STS_LSB 22
`define WOL_BIT_BADPW 20

// Index of the bad password flag in the flag vector
`define WOL_FLAG_BADPW 10

// Pattern length limits in bytes
`define WOL_PAT_MIN 8'h02
`define WOL_PAT_MAX_LO 64
`define WOL_PAT_MAX_HI 128

// Timing
`define WOL_CLK_NS 4
`define WOL_PME_PULSE_NS 100
`define WOL_PME_CYC \
   ((`WOL_PME_PULSE_NS + `WOL_CLK_NS - 1) / `WOL_CLK_NS)

`endif

//--- common/wol_pkg.sv
package wol_pkg;
   // Event output sequencer, one-hot
   typedef enum logic [1:0] {
      WOL_PME_IDLE = 2'b01,
      WOL_PME_PULSE = 2'b10
   } wol_pme_state_t;
endpackage

//--- rtl/wol_flag.sv
`timescale 1ns/100ps
`include "wol_defs.svh"

module wol_flag (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic soft_clr,
   input wire logic set,
   input wire logic rd_clr,
   // Flag
   output logic q
);
   logic q_r; // Sticky flag
   logic q_nxt; // Next value

   // Set beats read clear so no event is lost
   always_comb begin
      if (soft_clr) begin
         q_nxt = 1'b0;
      end else begin
         q_nxt = set | (q_r & ~rd_clr);
      end
   end

   // Flag register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r;

   // Event in the clearing read cycle survives
   property p_set_wins;
      @(posedge clk) disable iff (!rst_n)
      set && !soft_clr |=> q_r;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag set lost");
endmodule // wol_flag

//--- rtl/wol_pat_match.sv
`timescale 1ns/100ps
`include "wol_defs.svh"

module wol_pat_match #(
   parameter int MAXLEN = 64
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pattern memory programming
   input wire logic prog_we,
   input wire logic [6:0] prog_addr,
   input wire logic [7:0] prog_byte,
   input wire logic prog_mask,
   input wire logic cnt_we,
   input wire logic [7:0] cnt_in,
   // Received byte stream
   input wire logic rx_sof,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_eof,
   // Match pulse
   output logic hit
);
   localparam int AW = $clog2(MAXLEN);

   logic [8:0] mem [MAXLEN]; // Mask bit over pattern byte
   logic [7:0] cnt_r, cnt_nxt; // Pattern length
   logic [7:0] pos_r, pos_nxt; // Byte position in frame
   logic ok_r, ok_nxt; // All compared bytes agree
   logic hit_r, hit_nxt; // One-cycle match
   logic cnt_ok; // Length within limits
   logic [8:0] cur; // Pattern entry at position

   // Memory holds no reset; ok_r guards stale content
   always_ff @(posedge clk) begin
      if (prog_we) begin
         mem[prog_addr[AW-1:0]] <= {prog_mask, prog_byte};
      end
   end

   assign cur = mem[pos_r[AW-1:0]];
   // Short or oversize patterns never match
   assign cnt_ok = (cnt_r >= `WOL_PAT_MIN) && (cnt_r <= 8'(MAXLEN));

   // Byte-serial compare with don't-care bytes
   always_comb begin
      cnt_nxt = cnt_we ? cnt_in : cnt_r;
      pos_nxt = pos_r;
      ok_nxt = ok_r;
      hit_nxt = 1'b0;
      if (rx_sof) begin
         pos_nxt = 8'h00;
         ok_nxt = 1'b1;
      end else if (rx_valid && (pos_r < cnt_r)) begin
         // Masked bytes always agree
         if (!cur[8] && (cur[7:0] != rx_byte)) begin
            ok_nxt = 1'b0;
         end
         pos_nxt = pos_r + 8'h01;
      end
      // Whole pattern seen and agreed
      if (rx_eof) begin
         hit_nxt = ok_r && cnt_ok && (pos_r >= cnt_r);
      end
   end

   // Compare state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         pos_r <= 8'h00;
         ok_r <= 1'b0;
         hit_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         pos_r <= pos_nxt;
         ok_r <= ok_nxt;
         hit_r <= hit_nxt;
      end
   end

   assign hit = hit_r;

   property p_pat_len;
      @(posedge clk) disable iff (!rst_n)
      hit_r |-> $past(cnt_ok);
   endproperty
   a_pat_len: assert property (p_pat_len)
      else $error("match with bad pattern length");
endmodule // wol_pat_match

//--- rtl/wol_top.sv
`timescale 1ns/100ps
`include "wol_defs.svh"


module wol_top (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic RESET_N,
   input wire logic SOFT_RESET,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   // Receive filter classification pulses
   input wire logic MAGIC_SEEN,
   input wire logic MAGIC_PW_OK,
   input wire logic ARP_SEEN,
   input wire logic BCAST_SEEN,
   input wire logic GROUP_SEEN,
   input wire logic INDIV_SEEN,
   // Received byte stream for pattern compare
   input wire logic RX_SOF,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic RX_EOF,
   // Pattern memory programming
   input wire logic [1:0] PAT_SEL,
   input wire logic PAT_WR,
   input wire logic [6:0] PAT_ADDR,
   input wire logic [7:0] PAT_BYTE,
   input wire logic PAT_MASK,
   input wire logic PAT_CNT_WR,
   input wire logic [7:0] PAT_CNT,
   // PHY interrupt pin, asynchronous
   input wire logic PHY_INT,
   // Power state and descriptor status
   input wire logic LOW_POWER,
   input wire logic POWER_EVENT_OUT_EN,
   input wire logic RX_DESCRIPTOR_POINTER_NONNULL,
   // Wake outputs
   output logic POWER_EVENT_OUT_OE_N,
   output logic WAKE_INT,
   output logic RX_HOLD
);
   localparam logic [4:0] PME_CYC = 5'(`WOL_PME_CYC);

   logic [10:0] ctrl_r, ctrl_nxt; // Enable bits 10..0
   logic [10:0] flag_q; // Sticky status flags
   logic [10:0] flag_set; // Flag set terms
   logic [8:0] src; // Raw sources, aligned to enables
   logic [3:0] pat_hit; // Pattern match pulses
   logic rd_wake_control_status; // Read of the wake register
   logic wr_wake_control_status; // Write of the wake register
   logic pw_check; // Password protection in force
   logic wake_evt; // Any enabled wake source fired
   logic [31:0] word; // Register read image
   logic [31:0] rdata_r, rdata_nxt; // Read data
   logic phy_s1_r, phy_s2_r, phy_s3_r; // PHY pin sync
   logic phy_edge; // PHY interrupt rising edge
   wol_pkg::wol_pme_state_t pme_r, pme_nxt; // Event sequencer
   logic [4:0] pme_cnt_r, pme_cnt_nxt; // Pulse length count
   logic pme_oe_n_r, pme_oe_n_nxt; // Open-drain enable
   logic wint_r, wint_nxt; // Wake interrupt pulse
   logic hold_r, hold_nxt; // Wake frame held in FIFO

   // Address decode
   always_comb begin
      if (ADDR == `WOL_WAKE_CONTROL_STATUS_OFF) begin
         rd_wake_control_status = RD;
         wr_wake_control_status = WR;
      end else begin
         rd_wake_control_status = 1'b0;
         wr_wake_control_status = 1'b0;
      end
   end

   // PHY pin passes two flops before edge detection
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         phy_s1_r <= 1'b0;
         phy_s2_r <= 1'b0;
         phy_s3_r <= 1'b0;
      end else begin
         phy_s1_r <= PHY_INT;
         phy_s2_r <= phy_s1_r;
         phy_s3_r <= phy_s2_r;
      end
   end

   // Rising PHY interrupt is the PHY wake source
   assign phy_edge = phy_s2_r & ~phy_s3_r;

   // Pattern comparators, short pair then long pair
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pat
         wol_pat_match #(
            .MAXLEN(gi < 2 ? `WOL_PAT_MAX_LO : `WOL_PAT_MAX_HI)
         ) u_pat (
            .clk(REF_CLK),
            .rst_n(RESET_N),
            .prog_we(PAT_WR && (PAT_SEL == 2'(gi))),
            .prog_addr(PAT_ADDR),
            .prog_byte(PAT_BYTE),
            .prog_mask(PAT_MASK),
            .cnt_we(PAT_CNT_WR && (PAT_SEL == 2'(gi))),
            .cnt_in(PAT_CNT),
            .rx_sof(RX_SOF),
            .rx_valid(RX_VALID),
            .rx_byte(RX_BYTE),
            .rx_eof(RX_EOF),
            .hit(pat_hit[gi])
         );
      end
   endgenerate

   // Sources line up bit for bit with their enables
   assign src = {pat_hit, ARP_SEEN, BCAST_SEEN, GROUP_SEEN,
                 INDIV_SEEN, phy_edge};

   // Password check needs magic enable as well
   assign pw_check = ctrl_r[`WOL_BIT_PWPROT_EN] &
                     ctrl_r[`WOL_BIT_MAGIC_EN];

   // Flag set terms
   always_comb begin
      // Each class flag gated by its own enable
      flag_set[8:0] = src & ctrl_r[8:0];
      // Phy and unicast use the same gating
      // Magic accepted unless the password is wrong
      flag_set[9] = MAGIC_SEEN & ctrl_r[`WOL_BIT_MAGIC_EN] &
                    (~pw_check | MAGIC_PW_OK);
      // Wrong password counts as intrusion, no wake
      flag_set[`WOL_FLAG_BADPW] = MAGIC_SEEN & pw_check &
                                  ~MAGIC_PW_OK;
   end

   // Sticky flags, cleared by a read of the register
   generate
      for (gi = 0; gi < 11; gi++) begin : g_flag
         wol_flag u_flag (
            .clk(REF_CLK),
            .rst_n(RESET_N),
            .soft_clr(SOFT_RESET),
            .set(flag_set[gi]),
            .rd_clr(rd_wake_control_status),
            .q(flag_q[gi])
         );
      end
   endgenerate

   // Read image; reserved 21 and unused 19..11 read zero
   assign word = {flag_q[9:0], 1'b0, flag_q[`WOL_FLAG_BADPW],
                  9'h000, ctrl_r};

   // Any qualifying event wakes the system
   assign wake_evt = |flag_set[9:0];

   // Control, read data and wake sequencing
   always_comb begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = 32'h0000_0000;
      pme_nxt = pme_r;
      pme_cnt_nxt = pme_cnt_r;
      wint_nxt = 1'b0;
      hold_nxt = hold_r;
      // Writes reach enables only, never the flags
      if (wr_wake_control_status) begin
         ctrl_nxt = WDATA[10:0];
      end
      // Data stand only in the cycle after the read
      if (rd_wake_control_status) begin
         rdata_nxt = word;
      end
      // Fixed-length event pulse; retrigger ignored meanwhile
      case (pme_r)
         wol_pkg::WOL_PME_IDLE: begin
            if (wake_evt && LOW_POWER) begin
               pme_nxt = wol_pkg::WOL_PME_PULSE;
               pme_cnt_nxt = PME_CYC;
            end
         end
         wol_pkg::WOL_PME_PULSE: begin
            pme_cnt_nxt = pme_cnt_r - 5'h01;
            if (pme_cnt_r == 5'h01) begin
               pme_nxt = wol_pkg::WOL_PME_IDLE;
            end
         end
         default: begin
            pme_nxt = wol_pkg::WOL_PME_IDLE;
            pme_cnt_nxt = 5'h00;
         end
      endcase
      // Optional software notice of the wake
      wint_nxt = wake_evt & LOW_POWER;
      // Keep frame until a real descriptor exists
      if (wake_evt && LOW_POWER) begin
         hold_nxt = 1'b1;
      end else if (RX_DESCRIPTOR_POINTER_NONNULL) begin
         hold_nxt = 1'b0;
      end
      // Soft reset clears enables, event pulse, interrupt, hold and read data; pattern lengths are kept
      if (SOFT_RESET) begin
         ctrl_nxt = `WOL_CTRL_RST;
         pme_nxt = wol_pkg::WOL_PME_IDLE;
         pme_cnt_nxt = 5'h00;
         hold_nxt = 1'b0;
         wint_nxt = 1'b0;
         rdata_nxt = 32'h0000_0000;
      end
      // Pin drives low only while enabled
      pme_oe_n_nxt = ~((pme_nxt == wol_pkg::WOL_PME_PULSE) &
                       POWER_EVENT_OUT_EN);
   end

   // State registers; hard reset clears all
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_r <= `WOL_CTRL_RST;
         rdata_r <= `WOL_WAKE_CONTROL_STATUS_RST;
         pme_r <= wol_pkg::WOL_PME_IDLE;
         pme_cnt_r <= 5'h00;
         pme_oe_n_r <= 1'b1;
         wint_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         pme_r <= pme_nxt;
         pme_cnt_r <= pme_cnt_nxt;
         pme_oe_n_r <= pme_oe_n_nxt;
         wint_r <= wint_nxt;
         hold_r <= hold_nxt;
      end
   end

   assign RDATA = rdata_r;
   assign POWER_EVENT_OUT_OE_N = pme_oe_n_r;
   assign WAKE_INT = wint_r;
   assign RX_HOLD = hold_r;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   property p_magic;
      MAGIC_SEEN && ctrl_r[9] && (!pw_check || MAGIC_PW_OK) &&
         !SOFT_RESET ##1 !rd_wake_control_status && !SOFT_RESET ##1 rd_wake_control_status |=> RDATA[31];
   endproperty
   a_magic: assert property (p_magic)
      else $error("magic flag not reported");

   property p_pat_gate;
      !flag_q[5] && !ctrl_r[5] && !SOFT_RESET |=> !flag_q[5];
   endproperty
   a_pat_gate: assert property (p_pat_gate)
      else $error("pattern 0 flag set while disabled");

   property p_arp_clr;
      rd_wake_control_status && !flag_set[4] ##1 !flag_set[4] |-> !flag_q[4];
   endproperty
   a_arp_clr: assert property (p_arp_clr)
      else $error("arp flag not cleared by read");

   property p_badpw;
      MAGIC_SEEN && pw_check && !MAGIC_PW_OK && !SOFT_RESET
         |=> flag_q[10] && ($past(flag_q[9]) || !flag_q[9]);
   endproperty
   a_badpw: assert property (p_badpw)
      else $error("bad password not flagged or wrongly accepted");

   property p_pw_ignored;
      MAGIC_SEEN && ctrl_r[9] && !ctrl_r[10] && !SOFT_RESET
         |=> flag_q[9];
   endproperty
   a_pw_ignored: assert property (p_pw_ignored)
      else $error("magic rejected without password protection");

   property p_soft;
      SOFT_RESET |=> ctrl_r == 11'h000 && flag_q == 11'h000;
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset left state behind");

   property p_pulse;
      wake_evt && LOW_POWER && pme_r == wol_pkg::WOL_PME_IDLE &&
         !SOFT_RESET |=> (pme_r == wol_pkg::WOL_PME_PULSE)[*8];
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("event pulse missing or short");

   property p_oe_gate;
      !POWER_EVENT_OUT_EN |=> POWER_EVENT_OUT_OE_N;
   endproperty
   a_oe_gate: assert property (p_oe_gate)
      else $error("event output driven while disabled");

   property p_hold_rel;
      RX_HOLD && RX_DESCRIPTOR_POINTER_NONNULL && !(wake_evt && LOW_POWER)
         |=> !RX_HOLD;
   endproperty
   a_hold_rel: assert property (p_hold_rel)
      else $error("wake frame not released");

   property p_wr_ctrl;
      wr_wake_control_status && !SOFT_RESET |=> ctrl_r == $past(WDATA[10:0]);
   endproperty
   a_wr_ctrl: assert property (p_wr_ctrl)
      else $error("write did not reach enables");

   c_magic_wake: cover property (flag_set[9] && LOW_POWER);
   c_bad_pw: cover property (flag_set[10]);
   c_pat_hit: cover property (|pat_hit && |ctrl_r[8:5]);
   c_set_on_read: cover property (rd_wake_control_status && |flag_set);
endmodule // wol_top

//--- tb/wol_filter_model.sv
`timescale 1ns/100ps

module wol_filter_model (
   // Clock
   input wire logic clk,
   // Classifier pulses and PHY line
   output logic magic_seen,
   output logic magic_pw_ok,
   output logic [3:0] kind_seen, // Unicast, multicast, broadcast, ARP
   output logic phy_int,
   // Byte stream
   output logic rx_sof,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_eof
);
   // Quiet at time zero
   initial begin
      magic_seen = 1'b0;
      magic_pw_ok = 1'b0;
      kind_seen = 4'h0;
      phy_int = 1'b0;
      rx_sof = 1'b0;
      rx_valid = 1'b0;
      rx_byte = 8'hA5;
      rx_eof = 1'b0;
   end

   // One classification: 0..3 frame kinds, 4 PHY, 5 magic
   task automatic classify(input int k, input logic pw_ok);
      @(posedge clk);
      if (k == 5) begin
         magic_seen <= 1'b1;
         magic_pw_ok <= pw_ok;
      end else if (k == 4) begin
         phy_int <= 1'b1;
      end else begin
         kind_seen[k] <= 1'b1;
      end
      @(posedge clk);
      magic_seen <= 1'b0;
      magic_pw_ok <= ~pw_ok; // Meaningless outside the pulse
      kind_seen <= 4'h0;
      if (k == 4) begin
         // Two-flop sync inside, so hold the level a while
         repeat (4) @(posedge clk);
         phy_int <= 1'b0;
      end
   endtask

   // Frame of n bytes, one per cycle, between start and end marks
   task automatic frame(input logic [7:0] b [3], input int n);
      @(posedge clk);
      rx_sof <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         rx_sof <= 1'b0;
         rx_valid <= 1'b1;
         rx_byte <= b[i];
      end
      @(posedge clk);
      rx_sof <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte; // Stale byte must never look valid
      rx_eof <= 1'b1;
      @(posedge clk);
      rx_eof <= 1'b0;
   endtask
endmodule // wol_filter_model

//--- tb/wol_top_tb_top.sv
`timescale 1ns/100ps

module wol_top_tb_top;
   // Clock, resets and register port
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic soft_rst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   // Filter side, driven by the model
   logic magic_seen, magic_pw_ok, phy_int, rx_sof, rx_valid, rx_eof;
   logic [3:0] kind_seen;
   logic [7:0] rx_byte;
   // Pattern programming
   logic [1:0] pat_sel = 2'h0;
   logic pat_wr = 1'b0;
   logic [6:0] pat_addr = 7'h00;
   logic [7:0] pat_byte = 8'h00;
   logic pat_mask = 1'b0;
   logic pat_cnt_wr = 1'b0;
   logic [7:0] pat_cnt = 8'h00;
   // Power state; null descriptor loaded before sleeping
   logic low_power = 1'b0;
   logic pe_en = 1'b0;
   logic rx_descriptor_pointer_ok = 1'b0;
   logic oe_n, wake_int, rx_hold;
   // Bench state and magic frame table
   int num_errors = 0;
   int num_checks = 0;
   int cnt;
   logic [31:0] d, w;
   logic [10:0] en;
   logic [7:0] b [3];
   logic [10:0] men [5] = '{11'h200, 11'h600, 11'h600, 11'h400, 11'h1FF};
   logic mpw [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   int mflag [5] = '{31, 20, 31, -1, -1};

   // 250 MHz clock
   always #2 ref_clk = ~ref_clk;

   wol_top i_wol_top (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .SOFT_RESET(soft_rst),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .MAGIC_SEEN(magic_seen), .MAGIC_PW_OK(magic_pw_ok),
      .ARP_SEEN(kind_seen[3]), .BCAST_SEEN(kind_seen[2]),
      .GROUP_SEEN(kind_seen[1]), .INDIV_SEEN(kind_seen[0]),
      .RX_SOF(rx_sof), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
      .RX_EOF(rx_eof), .PAT_SEL(pat_sel), .PAT_WR(pat_wr),
      .PAT_ADDR(pat_addr), .PAT_BYTE(pat_byte), .PAT_MASK(pat_mask),
      .PAT_CNT_WR(pat_cnt_wr), .PAT_CNT(pat_cnt), .PHY_INT(phy_int),
      .LOW_POWER(low_power), .POWER_EVENT_OUT_EN(pe_en),
      .RX_DESCRIPTOR_POINTER_NONNULL(rx_descriptor_pointer_ok), .POWER_EVENT_OUT_OE_N(oe_n),
      .WAKE_INT(wake_int), .RX_HOLD(rx_hold)
   );

   wol_filter_model i_wol_filter_model (
      .clk(ref_clk), .magic_seen(magic_seen), .magic_pw_ok(magic_pw_ok),
      .kind_seen(kind_seen), .phy_int(phy_int), .rx_sof(rx_sof),
      .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_eof(rx_eof)
   );

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected register image: one flag (or none) plus enables
   function automatic logic [31:0] word(input int f, input logic [10:0] e);
      word = {21'h0, e};
      if (f >= 0)
         word[f] = 1'b1;
   endfunction

   // One-cycle write strobe
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // Read strobe; data stands only in the following cycle
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   // Entries 0 and 1 (second masked), then the length
   task automatic prog(input logic [1:0] p, input logic [7:0] len);
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk);
         pat_sel <= p;
         pat_wr <= (i < 2);
         pat_addr <= 7'(i);
         pat_byte <= b[i];
         pat_mask <= (i == 1);
         pat_cnt_wr <= (i == 2);
         pat_cnt <= len;
      end
      @(posedge ref_clk);
      pat_wr <= 1'b0;
      pat_cnt_wr <= 1'b0;
   endtask

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard
   initial begin
      #100000;
      num_errors++;
      print_verdict();
   end

   initial begin
      w = $urandom(77);
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      reg_rd(8'h40, d);
      check(d, 32'h0);
      // Random writes, stray bits and an unmapped address ignored
      for (int i = 0; i < 6; i++) begin
         w = $urandom;
         reg_wr(8'h40, w);
         reg_wr(8'h44, ~w);
         reg_rd(8'h40, d);
         check(d, word(-1, w[10:0]));
      end
      reg_rd(8'h44, d);
      check(d, 32'h0);
      // Each frame kind and the PHY, enabled alone or masked out
      for (int k = 0; k < 5; k++) begin
         for (int on = 0; on < 2; on++) begin
            cnt = (k == 4) ? 0 : k + 1;
            en = on ? 11'h1 << cnt : 11'h7FF ^ (11'h1 << cnt);
            reg_wr(8'h40, {21'h0, en});
            i_wol_filter_model.classify(k, 1'b1);
            reg_rd(8'h40, d);
            w = word(on ? ((k == 4) ? 22 : 23 + k) : -1, en);
            check(d, w);
            reg_rd(8'h40, d);
            check(d, word(-1, en));
         end
      end
      // Magic frames under each password setting
      for (int i = 0; i < 5; i++) begin
         en = men[i];
         reg_wr(8'h40, {21'h0, en});
         i_wol_filter_model.classify(5, mpw[i]);
         reg_rd(8'h40, d);
         check(d, word(mflag[i], en));
      end
      // Each pattern at the minimum length, masked byte differs
      for (int p = 0; p < 4; p++) begin
         en = 11'h020 << p;
         reg_wr(8'h40, {21'h0, en});
         for (int i = 0; i < 3; i++)
            b[i] = 8'($urandom);
         prog(2'(p), 8'h02);
         b[1] = ~b[1];
         i_wol_filter_model.frame(b, 3);
         repeat (2) @(posedge ref_clk);
         reg_rd(8'h40, d);
         check(d, word(27 + p, en));
         // Short frame, unmasked byte wrong, then a length below minimum
         i_wol_filter_model.frame(b, 1);
         b[0] = ~b[0];
         i_wol_filter_model.frame(b, 3);
         prog(2'(p), 8'h01);
         i_wol_filter_model.frame(b, 3);
         repeat (2) @(posedge ref_clk);
         reg_rd(8'h40, d);
         check(d, word(-1, en));
      end
      // Wake in low power, event pin enabled then disabled
      for (int e = 1; e >= 0; e--) begin
         @(posedge ref_clk);
         pe_en <= e[0];
         low_power <= 1'b1;
         reg_wr(8'h40, 32'h10);
         i_wol_filter_model.classify(3, 1'b1);
         #1 check({31'h0, wake_int}, 32'h1);
         cnt = 0;
         for (int i = 0; i < 40; i++) begin
            cnt += (oe_n === 1'b0);
            @(posedge ref_clk);
            #1;
         end
         check(32'(cnt), e ? 32'h19 : 32'h0);
         check({31'h0, rx_hold}, 32'h1);
         reg_rd(8'h40, d);
         check(d, word(26, 11'h010));
      end
      // Valid descriptor releases the held frame
      @(posedge ref_clk);
      rx_descriptor_pointer_ok <= 1'b1;
      low_power <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check({31'h0, rx_hold}, 32'h0);
      // Soft reset wipes enables and a pending flag
      reg_wr(8'h40, 32'h7FF);
      i_wol_filter_model.classify(3, 1'b1);
      @(posedge ref_clk);
      soft_rst <= 1'b1;
      @(posedge ref_clk);
      soft_rst <= 1'b0;
      reg_rd(8'h40, d);
      check(d, 32'h0);
      // Hard reset in mid run
      reg_wr(8'h40, 32'h7FF);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      @(posedge ref_clk);
      reset_n <= 1'b1;
      reg_rd(8'h40, d);
      check(d, 32'h0);
      print_verdict();
   end
endmodule // wol_top_tb_top
